// >>> data_address_generator.sv
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
//
// Contract
// (RULE1) three 12-bit pointer pairs, high plus low
// (RULE2) virtual operands access memory at pair address
// (RULE3) pointer access ignores bank select, access bit
// (RULE4) post-decrement: use pointer, then decrement
// (RULE5) post-increment: use pointer, then increment
// (RULE6) pre-increment: increment first, then use
// (RULE7) offset operand: pointer plus signed working register
// (RULE8) plain operand: pointer address, pointer unchanged
// (RULE9) steps act on whole 12-bit pair
// (RULE10) pointer steps never touch status flags
// (RULE11) indirect read of virtual operand returns zero
// (RULE12) indirect write of virtual operand does nothing
// (RULE13) own-operand write to pair: store, no step
// (RULE14) pointers directly accessible; other registers indirectly
// (RULE15) extended, forced, address<=5Fh: pair two plus address
// (RULE16) extended, forced, address>=60h: top bank
// (RULE17) access bit set: bank select plus address
// (RULE18) extended mode leaves pairs zero, one unchanged
// (RULE19) inherent, literal instructions unaffected by mode
// (RULE20) destination bit: 1 file register, 0 working
// (RULE21) access bit 0 selects access bank
// (RULE22) indexed window spans pair two plus 5Fh
// (RULE23) pointer plus offset sums wrap 12 bits
//
module data_address_generator
   import dag_pkg::*;
#(
   parameter int PAIRS = 3
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // core request
   input wire logic req_valid,
   input wire logic req_literal,
   input wire logic [7:0] req_file_addr,
   input wire logic req_access_bit,
   input wire logic req_write,
   input wire logic req_dest_bit,
   input wire logic req_commit,
   input wire logic [7:0] req_wdata,
   input wire logic [7:0] working_reg,
   input wire logic [3:0] bank_select,
   // data memory
   output logic [11:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // results to core
   output logic w_wr,
   output logic [7:0] w_wdata,
   output logic [7:0] core_rdata,
   output logic core_rvalid,
   // mode state
   output logic ext_mode
);

   localparam int PW = 2;

   // register map and indexed window hold exactly three pairs
   if (PAIRS != 3) begin : g_pairs_check
      $error("PAIRS must be 3");
   end

   function automatic logic [11:0] vbase(input int n);
      vbase = VIRT_BASE0 - (12'(n) * VIRT_STRIDE);
   endfunction

   // state
   logic mode_reg;
   logic [7:0] reg_rdata_reg;
   logic [7:0] reg_rdata_next;
   logic [11:0] mem_addr_reg;
   logic mem_rd_reg;
   logic mem_wr_reg;
   logic [7:0] mem_wdata_reg;
   logic w_wr_reg;
   logic [7:0] w_wdata_reg;
   logic [7:0] core_rdata_reg;
   logic [7:0] core_rdata_next;
   logic core_rvalid_reg;
   rsrc_t src1_reg;
   rsrc_t src2_reg;
   rsrc_t src_next;
   logic [7:0] byte1_reg;
   logic [7:0] byte2_reg;

   // pointer values and per-pair decode
   logic [11:0] ptr [PAIRS];
   logic [PAIRS-1:0] dhit;
   logic [2:0] dop [PAIRS];
   logic [PAIRS-1:0] thit;
   logic [PAIRS-1:0] tlo;
   logic [PAIRS-1:0] thi;

   // request qualification
   wire acc = req_valid && !req_literal; // RULE19
   wire rd_req = acc && !req_write;
   wire to_file = acc && req_write && req_dest_bit; // RULE20
   wire to_work = acc && req_write && !req_dest_bit; // RULE20

   // direct address forming
   wire xmode = mode_reg;
   wire idx_hit = xmode && !req_access_bit && (req_file_addr <= IDX_LIMIT); // RULE15
   wire [11:0] bank_addr = {bank_select, req_file_addr}; // RULE17 RULE21
   wire acc_top = req_file_addr >= ACC_SPLIT;
   wire [11:0] acc_addr = acc_top ? {TOP_BANK, req_file_addr} : {LOW_BANK, req_file_addr}; // RULE16 RULE21
   wire [11:0] idx_addr = ptr[2] + {4'h0, req_file_addr}; // RULE22 RULE23
   wire [11:0] dir_addr = req_access_bit ? bank_addr : (idx_hit ? idx_addr : acc_addr);

   // indirect selection
   logic ind_hit;
   logic [PW-1:0] ind_pair;
   vop_t ind_op;

   always_comb begin
      ind_hit = 1'b0;
      ind_pair = '0;
      ind_op = OP_PLAIN;
      for (int n = 0; n < PAIRS; n++) begin
         if (dhit[n] && !idx_hit) begin // RULE22
            ind_hit = 1'b1;
            ind_pair = PW'(n);
            ind_op = vop_t'(dop[n]);
         end
      end
   end

   // selected pointer and its offsets
   wire [11:0] ind_ptr = ptr[ind_pair];
   wire [11:0] w_ext = {{4{working_reg[7]}}, working_reg};
   wire [11:0] ptr_inc = ind_ptr + 12'h001;
   wire [11:0] ptr_working_offset_operand = ind_ptr + w_ext; // RULE7 RULE23

   // indirect address ignores bank select and access bit
   wire [11:0] ind_addr = (ind_op == OP_PRE_INCREMENT_OPERAND) ? ptr_inc : // RULE6
      (ind_op == OP_WORKING_OFFSET_OPERAND) ? ptr_working_offset_operand : ind_ptr; // RULE3 RULE4 RULE5 RULE8
   wire [11:0] fin_addr = ind_hit ? ind_addr : dir_addr; // RULE2

   // target classification
   wire tgt_virt = ind_hit && (|thit); // RULE11 RULE12
   wire tgt_sfr = (|tlo) || (|thi); // RULE14
   wire own_write = ind_hit && to_file && (tlo[ind_pair] || thi[ind_pair]); // RULE13
   wire no_mem = tgt_virt || tgt_sfr;

   // step of the selected pair; status flags live elsewhere
   wire nop_write = to_file && tgt_virt; // RULE12
   wire step_en = acc && req_commit && ind_hit && !own_write && !nop_write; // RULE10 RULE13
   step_t op_step;

   always_comb begin
      op_step = STEP_NONE;
      case (ind_op)
         OP_POST_DECREMENT_OPERAND: op_step = STEP_DEC; // RULE4
         OP_POST_INCREMENT_OPERAND: op_step = STEP_INC; // RULE5
         OP_PRE_INCREMENT_OPERAND: op_step = STEP_INC; // RULE6
         default: op_step = STEP_NONE;
      endcase
   end

   // pointer byte seen at the final target
   logic [7:0] sfr_byte;

   always_comb begin
      sfr_byte = ZERO_BYTE;
      for (int n = 0; n < PAIRS; n++) begin
         if (tlo[n]) begin
            sfr_byte = ptr[n][7:0];
         end
         if (thi[n]) begin
            sfr_byte = {HI_UNUSED, ptr[n][11:8]};
         end
      end
   end

   // per-pair decode, writes and storage
   for (genvar n = 0; n < PAIRS; n++) begin : g_pair
      localparam logic [11:0] VB = vbase(n);
      localparam logic [2:0] RHI = 3'(2 * n);
      localparam logic [2:0] RLO = 3'(2 * n + 1);
      // byte writes; the register port beats the core
      wire reg_hi = reg_wr && (reg_addr == RHI); // RULE14
      wire reg_lo = reg_wr && (reg_addr == RLO); // RULE14
      wire reg_any = reg_hi || reg_lo;
      wire core_ok = to_file && !tgt_virt && !reg_any;
      wire wr_hi = reg_hi || (core_ok && thi[n]); // RULE13 RULE14
      wire wr_lo = reg_lo || (core_ok && tlo[n]); // RULE13 RULE14
      wire [7:0] wbyte = reg_any ? reg_wdata : req_wdata;
      wire step_t step = (step_en && (ind_pair == PW'(n))) ? op_step : STEP_NONE; // RULE18

      // operand and pointer byte decode
      assign dhit[n] = (dir_addr <= VB) && (dir_addr >= (VB - VIRT_SPAN));
      assign dop[n] = 3'(VB - dir_addr);
      assign thit[n] = (fin_addr <= VB) && (fin_addr >= (VB - VIRT_SPAN));
      assign tlo[n] = fin_addr == (VB - SFR_LO_OFS);
      assign thi[n] = fin_addr == (VB - SFR_HI_OFS);

      pointer_pair u_pair ( // RULE1
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .wr_hi(wr_hi),
         .wr_lo(wr_lo),
         .wdata(wbyte),
         .step(step),
         .value(ptr[n])
      );
   end

   // register port read mux
   always_comb begin
      reg_rdata_next = ZERO_BYTE;
      case (reg_addr)
         REG_P0_HI: reg_rdata_next = {HI_UNUSED, ptr[0][11:8]}; // RULE1
         REG_P0_LO: reg_rdata_next = ptr[0][7:0];
         REG_P1_HI: reg_rdata_next = {HI_UNUSED, ptr[1][11:8]}; // RULE1
         REG_P1_LO: reg_rdata_next = ptr[1][7:0];
         REG_P2_HI: reg_rdata_next = {HI_UNUSED, ptr[2][11:8]}; // RULE1
         REG_P2_LO: reg_rdata_next = ptr[2][7:0];
         REG_MODE: reg_rdata_next = {7'h00, mode_reg};
         default: reg_rdata_next = ZERO_BYTE;
      endcase
   end

   // mode register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mode_reg <= MODE_RESET;
      end else if (reg_wr && (reg_addr == REG_MODE)) begin
         mode_reg <= reg_wdata[MODE_XBIT];
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_rdata_reg <= RDATA_RESET;
      end else if (reg_rd) begin
         reg_rdata_reg <= reg_rdata_next;
      end else begin
         reg_rdata_reg <= RDATA_RESET;
      end
   end

   // memory request stage
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mem_addr_reg <= ADDR_RESET;
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         mem_wdata_reg <= ZERO_BYTE;
      end else begin
         mem_addr_reg <= fin_addr;
         mem_rd_reg <= rd_req && !no_mem; // RULE11
         mem_wr_reg <= to_file && !no_mem; // RULE12 RULE20
         mem_wdata_reg <= req_wdata;
      end
   end

   // working register result
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         w_wr_reg <= 1'b0;
         w_wdata_reg <= ZERO_BYTE;
      end else begin
         w_wr_reg <= to_work; // RULE20
         w_wdata_reg <= req_wdata;
      end
   end

   // read source of the current request
   always_comb begin
      src_next = SRC_NONE;
      if (rd_req) begin
         if (tgt_virt) begin
            src_next = SRC_ZERO; // RULE11
         end else if (tgt_sfr) begin
            src_next = SRC_PTR; // RULE14
         end else begin
            src_next = SRC_MEM;
         end
      end
   end

   // read pipeline, matched to the memory's one-cycle latency
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         src1_reg <= SRC_NONE;
         src2_reg <= SRC_NONE;
         byte1_reg <= ZERO_BYTE;
         byte2_reg <= ZERO_BYTE;
      end else begin
         src1_reg <= src_next;
         src2_reg <= src1_reg;
         byte1_reg <= sfr_byte;
         byte2_reg <= byte1_reg;
      end
   end

   // read result select
   always_comb begin
      core_rdata_next = ZERO_BYTE;
      case (src2_reg)
         SRC_MEM: core_rdata_next = mem_rdata;
         SRC_PTR: core_rdata_next = byte2_reg;
         SRC_ZERO: core_rdata_next = ZERO_BYTE; // RULE11
         default: core_rdata_next = ZERO_BYTE;
      endcase
   end

   // read result register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         core_rdata_reg <= ZERO_BYTE;
         core_rvalid_reg <= 1'b0;
      end else begin
         core_rdata_reg <= core_rdata_next;
         core_rvalid_reg <= src2_reg != SRC_NONE;
      end
   end

   // outputs
   assign reg_rdata = reg_rdata_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_rd = mem_rd_reg;
   assign mem_wr = mem_wr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign w_wr = w_wr_reg;
   assign w_wdata = w_wdata_reg;
   assign core_rdata = core_rdata_reg;
   assign core_rvalid = core_rvalid_reg;
   assign ext_mode = mode_reg;

endmodule

// >>> dag_pkg.sv
package dag_pkg;

   // data address width and byte width
   localparam int ADDR_W = 12;
   localparam int BYTE_W = 8;

   // register port indices: pair n high at 2n, low at 2n+1
   localparam logic [2:0] REG_P0_HI = 3'h0;
   localparam logic [2:0] REG_P0_LO = 3'h1;
   localparam logic [2:0] REG_P1_HI = 3'h2;
   localparam logic [2:0] REG_P1_LO = 3'h3;
   localparam logic [2:0] REG_P2_HI = 3'h4;
   localparam logic [2:0] REG_P2_LO = 3'h5;
   localparam logic [2:0] REG_MODE = 3'h6;
   localparam int MODE_XBIT = 0;

   // reset values
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [11:0] ADDR_RESET = 12'h000;
   localparam logic MODE_RESET = 1'b0;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // virtual operand map: pair n plain operand at VIRT_BASE0 - n*VIRT_STRIDE,
   // the other four operands just below it
   localparam logic [11:0] VIRT_BASE0 = 12'hFEF;
   localparam logic [11:0] VIRT_STRIDE = 12'h008;
   localparam logic [11:0] VIRT_SPAN = 12'h004;
   localparam logic [11:0] SFR_LO_OFS = 12'h006;
   localparam logic [11:0] SFR_HI_OFS = 12'h005;

   // access bank split and indexed window limit
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam logic [3:0] TOP_BANK = 4'hF;
   localparam logic [3:0] LOW_BANK = 4'h0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] HI_UNUSED = 4'h0;

   // virtual operand kinds, in order of distance below the plain operand
   typedef enum logic [2:0] {
      OP_PLAIN,
      OP_POST_INCREMENT_OPERAND,
      OP_POST_DECREMENT_OPERAND,
      OP_PRE_INCREMENT_OPERAND,
      OP_WORKING_OFFSET_OPERAND
   } vop_t;

   // pointer step commands
   typedef enum logic [1:0] {
      STEP_NONE,
      STEP_INC,
      STEP_DEC
   } step_t;

   // where read data comes from
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_MEM,
      SRC_ZERO,
      SRC_PTR
   } rsrc_t;

endpackage

// >>> pointer_pair.sv
`timescale 1ns/10ps
module pointer_pair
   import dag_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // byte writes
   input wire logic wr_hi,
   input wire logic wr_lo,
   input wire logic [7:0] wdata,
   // automatic step
   input wire step_t step,
   // pair value
   output logic [11:0] value
);

   logic [11:0] value_reg;
   logic [11:0] value_next;

   always_comb begin
      value_next = value_reg;
      if (wr_hi || wr_lo) begin
         if (wr_hi) begin
            value_next[11:8] = wdata[3:0];
         end
         if (wr_lo) begin
            value_next[7:0] = wdata;
         end
      end else begin
         case (step)
            STEP_INC: value_next = value_reg + 12'h001; // RULE9
            STEP_DEC: value_next = value_reg - 12'h001; // RULE9
            default: value_next = value_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         value_reg <= PTR_RESET;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;

endmodule

// >>> dag_assertions.sv
`timescale 1ns/10ps
module dag_checker
   import dag_pkg::*;
#(
   parameter int PAIRS = 3
)
(
   // clock, reset, register port
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // core request
   input wire logic req_valid,
   input wire logic req_literal,
   input wire logic [7:0] req_file_addr,
   input wire logic req_access_bit,
   input wire logic req_write,
   input wire logic req_dest_bit,
   input wire logic [7:0] req_wdata,
   input wire logic [3:0] bank_select,
   // results
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic w_wr,
   input wire logic [7:0] w_wdata,
   input wire logic core_rvalid,
   input wire logic ext_mode
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   wire acc = req_valid && !req_literal;
   wire rd_req = acc && !req_write;
   wire bank_ok = req_access_bit && bank_select != TOP_BANK;

   a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data without read");
   a_mode_set: assert property (reg_wr && reg_addr == REG_MODE && reg_wdata[0]
      |=> ext_mode) else $error("mode bit not set");
   a_literal_quiet: assert property (req_valid && req_literal
      |=> !mem_rd && !mem_wr && !w_wr) else $error("literal touched memory");
   a_bank_read: assert property (rd_req && bank_ok
      |=> mem_rd && mem_addr == {$past(bank_select), $past(req_file_addr)})
      else $error("bank read address");
   a_top_read: assert property (rd_req && !req_access_bit && req_file_addr >= ACC_SPLIT
      && req_file_addr < 8'hD9 |=> mem_rd && mem_addr == {TOP_BANK, $past(req_file_addr)})
      else $error("top bank address");
   a_dest_work: assert property (acc && req_write && !req_dest_bit
      |=> w_wr && !mem_wr && w_wdata == $past(req_wdata)) else $error("working write");
   a_dest_file: assert property (acc && req_write && req_dest_bit && bank_ok
      |=> mem_wr && !w_wr && mem_wdata == $past(req_wdata)
      && mem_addr == {$past(bank_select), $past(req_file_addr)}) else $error("file write");
   a_read_lat: assert property (core_rvalid |-> $past(rd_req, 3))
      else $error("read result without request");
   a_mem_cause: assert property (mem_rd || mem_wr || w_wr |-> $past(acc))
      else $error("access without request");
endmodule

bind data_address_generator dag_checker #(.PAIRS(PAIRS)) chk (.ref_clk, .rst_b,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_literal,
   .req_file_addr, .req_access_bit, .req_write, .req_dest_bit, .req_wdata, .bank_select,
   .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .w_wr, .w_wdata, .core_rvalid, .ext_mode);

// >>> data_memory_model.sv
`timescale 1ns/10ps
module data_memory_model
(
   // memory port
   input wire logic ref_clk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] ram [4096];
   initial begin
      mem_rdata = 8'h00;
      for (int i = 0; i < 4096; i++) ram[i] = i[7:0] ^ {i[11:8], i[11:8]};
   end
   // data only in the cycle after a read, toggling otherwise
   always @(posedge ref_clk) begin
      if (mem_wr) ram[mem_addr] <= mem_wdata;
      mem_rdata <= mem_rd ? ram[mem_addr] : ~mem_rdata;
   end
endmodule

// >>> data_address_generator_tb_top.sv
`timescale 1ns/10ps
module data_address_generator_tb_top;
   import dag_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
   logic req_literal = 1'b0, req_access_bit = 1'b0, req_write = 1'b0, req_dest_bit = 1'b0;
   logic req_commit = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, req_file_addr = 8'h00, req_wdata = 8'h00;
   logic [7:0] working_reg = 8'h00;
   logic [3:0] bank_select = 4'h0;
   logic [7:0] reg_rdata, mem_wdata, mem_rdata, w_wdata, core_rdata;
   logic [11:0] mem_addr;
   logic mem_rd, mem_wr, w_wr, core_rvalid, ext_mode;
   int bad_count = 0, samples_checked = 0;
   logic [7:0] q_reg[$], q_cr[$], q_w[$], q_wd[$], shadow[4096];
   logic [11:0] q_ma[$];
   logic [31:0] seed = 32'h52, r;
   logic rd_d = 1'b0;

   data_address_generator #(.PAIRS(3)) dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_literal, .req_file_addr,
      .req_access_bit, .req_write, .req_dest_bit, .req_commit, .req_wdata,
      .working_reg, .bank_select, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
      .w_wr, .w_wdata, .core_rdata, .core_rvalid, .ext_mode);
   data_memory_model mem (.ref_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

   always #20 ref_clk = ~ref_clk;

   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   task cmp12(input string n, input logic [11:0] e, input logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   // register access; for reads d is the expected byte
   task rg(input logic w, input logic [2:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      req_valid <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) q_reg.push_back(d);
      @(posedge ref_clk);
   endtask

   task setp(input logic [2:0] hi, input logic [11:0] v);
      rg(1'b1, hi, {4'h0, v[11:8]});
      rg(1'b1, hi + 3'h1, v[7:0]);
   endtask

   task core(input logic lit, a, wr, d, input logic [7:0] f, wd, input logic hit,
             input logic [11:0] ea, input logic [7:0] ed);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      req_valid <= 1'b1;
      {req_literal, req_access_bit, req_write, req_dest_bit} <= {lit, a, wr, d};
      req_file_addr <= f;
      req_wdata <= wd;
      if (hit) q_ma.push_back(ea);
      if (!lit && !wr) q_cr.push_back(hit ? shadow[ea] : ed);
      if (wr && hit) shadow[ea] = wd;
      if (!lit && wr && hit) q_wd.push_back(wd);
      if (!lit && wr && !d) q_w.push_back(wd);
      @(posedge ref_clk);
   endtask

   task rd(input logic a, input logic [7:0] f, input logic [11:0] ea);
      core(1'b0, a, 1'b0, 1'b0, f, 8'h00, 1'b1, ea, 8'h00);
   endtask

   task rz(input logic [7:0] f, input logic [7:0] ed);
      core(1'b0, 1'b0, 1'b0, 1'b0, f, 8'h00, 1'b0, 12'h000, ed);
   endtask

   task end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // result monitor
   always @(posedge ref_clk) rd_d <= reg_rd && rst_b;
   always @(negedge ref_clk) begin
      if (rd_d)
         cmp8("reg_rdata", q_reg.size() ? q_reg.pop_front() : 8'hXX, reg_rdata);
      if (core_rvalid !== 1'b0)
         cmp8("core_rdata", q_cr.size() ? q_cr.pop_front() : 8'hXX, core_rdata);
      if ((mem_rd || mem_wr) !== 1'b0)
         cmp12("mem_addr", q_ma.size() ? q_ma.pop_front() : 12'hXXX, mem_addr);
      if (mem_wr !== 1'b0)
         cmp8("mem_wdata", q_wd.size() ? q_wd.pop_front() : 8'hXX, mem_wdata);
      if (w_wr !== 1'b0)
         cmp8("w_wdata", q_w.size() ? q_w.pop_front() : 8'hXX, w_wdata);
   end

   initial begin
      #(1000 * 40);
      $display("[ERR] watchdog exp finish got timeout");
      bad_count++;
      end_of_test();
   end

   initial begin
      for (int i = 0; i < 4096; i++) shadow[i] = i[7:0] ^ {i[11:8], i[11:8]};
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++) rg(1'b0, i[2:0], 8'h00);
      setp(REG_P0_HI, 12'h1FE);
      rg(1'b1, REG_P0_HI, 8'hF1);
      rg(1'b0, REG_P0_HI, 8'h01);
      bank_select <= 4'hF;
      rd(1'b1, 8'hEE, 12'h1FE);
      rd(1'b0, 8'hEE, 12'h1FF);
      rd(1'b0, 8'hEE, 12'h200);
      rd(1'b0, 8'hED, 12'h201);
      rd(1'b0, 8'hEC, 12'h201);
      rd(1'b0, 8'hEF, 12'h201);
      working_reg <= 8'h80;
      rd(1'b0, 8'hEB, 12'h181);
      working_reg <= 8'h7F;
      rd(1'b0, 8'hEB, 12'h280);
      rg(1'b0, REG_P0_LO, 8'h01);
      setp(REG_P1_HI, 12'h000);
      rd(1'b0, 8'hE5, 12'h000);
      working_reg <= 8'h20;
      rd(1'b0, 8'hE3, 12'h01F);
      setp(REG_P0_HI, 12'hFE7);
      rz(8'hEF, 8'h00);
      core(1'b0, 1'b0, 1'b1, 1'b1, 8'hEF, 8'h55, 1'b0, 12'h000, 8'h00);
      setp(REG_P0_HI, 12'hFE9);
      rz(8'hEF, 8'hE9);
      setp(REG_P2_HI, 12'hFD9);
      core(1'b0, 1'b0, 1'b1, 1'b1, 8'hDD, 8'h34, 1'b0, 12'h000, 8'h00);
      rg(1'b0, REG_P2_LO, 8'h34);
      rg(1'b0, REG_P2_HI, 8'h0F);
      bank_select <= 4'h2;
      core(1'b0, 1'b1, 1'b1, 1'b0, 8'h10, 8'hA5, 1'b0, 12'h000, 8'h00);
      core(1'b0, 1'b1, 1'b1, 1'b1, 8'h11, 8'hA6, 1'b1, 12'h211, 8'h00);
      rd(1'b1, 8'h11, 12'h211);
      for (int i = 0; i < 8; i++) begin
         r = xs();
         bank_select <= r[3:0] & 4'hE;
         rd(1'b1, r[15:8], {r[3:0] & 4'hE, r[15:8]});
         rd(1'b0, r[23:16] & 8'h3F, {4'h0, r[23:16] & 8'h3F});
      end
      core(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 12'h000, 8'h00);
      rg(1'b1, REG_MODE, 8'h01);
      rg(1'b0, REG_MODE, 8'h01);
      setp(REG_P2_HI, 12'hFC0);
      setp(REG_P0_HI, 12'h345);
      rd(1'b0, 8'h5F, 12'h01F);
      rd(1'b0, 8'h00, 12'hFC0);
      rd(1'b0, 8'h60, 12'hF60);
      rd(1'b0, 8'hDF, 12'hFC0);
      rd(1'b0, 8'hEF, 12'h345);
      rz(8'hEA, 8'h03);
      core(1'b0, 1'b0, 1'b1, 1'b1, 8'hE9, 8'h77, 1'b0, 12'h000, 8'h00);
      rg(1'b0, REG_P0_LO, 8'h77);
      req_commit <= 1'b0;
      rd(1'b0, 8'hEE, 12'h377);
      req_commit <= 1'b1;
      rd(1'b0, 8'hEF, 12'h377);
      bank_select <= 4'h3;
      rd(1'b1, 8'h20, 12'h320);
      core(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 12'h000, 8'h00);
      reg_rd <= 1'b0;
      req_valid <= 1'b0;
      repeat (6) @(posedge ref_clk);
      cmp12("pending", 12'h000, 12'(q_reg.size() + q_cr.size() + q_ma.size()
         + q_w.size() + q_wd.size()));
      end_of_test();
   end
endmodule
